// *** verilog/bfrs_top.sv ***
// Register bank and fault response selection for the low-voltage bus faults.
//
// Function
// - Phase fault enable clear means no fault.
// - Too many phases disabled triggers selected response.
// - Individual enable set uses register response fields.
// - Individual enable clear uses strapped mode response.
// - Overvoltage flag-only sets status, pulls flag.
// - Overvoltage hiccup stops, restarts 500 ms later.
// - Overvoltage latch-off stops until enable toggle.
// - Code 11 behaves as flag only.
// - Undervoltage flag-only sets status, pulls flag.
// - Undervoltage hiccup stops, resumes 500 ms later.
// - Undervoltage latch-off stops until enable toggle.
// - Response register byte, R/W, reset zero.
// - Overcurrent/phase field: flag, hiccup, latch encodings.
`timescale 1ns/1ps
module bfrs_top
   import bfrs_pkg::*;
#(
   parameter int unsigned HICCUP_CYCLES = HICCUP_CYC,
   parameter int          PHASES        = MAX_PHASES
)
(
   input  wire logic               clock,
   input  wire logic               nrst,
   input  wire logic               reg_wr_en,
   input  wire logic               reg_rd_en,
   input  wire logic [7:0]         reg_addr,
   input  wire logic [7:0]         reg_wdata,
   output logic      [7:0]         reg_rdata,
   input  wire logic               indiv_resp_en,
   input  wire logic [1:0]         mode_resp,
   input  wire logic [PHASES-1:0]  phase_disable_mask,
   input  wire logic [PHASE_W-1:0] phase_count,
   input  wire logic               bus_ov_cond,
   input  wire logic               bus_uv_cond,
   input  wire logic               switch_en,
   input  wire logic               chip_en,
   output logic                    switch_stop,
   output logic                    fault_flag_out_n_o,
   output logic                    fault_flag_out_n_oe
);
   if (PHASES < 1 || PHASES > MAX_PHASES)
   begin : g_chk
      $error("PHASES out of range");
   end

   // Counts the phases that software has masked off.
   function automatic logic [PHASE_W:0] bfrs_popcount(input logic [PHASES-1:0] v);
      logic [PHASE_W:0] n;
      n = '0;
      for (int i = 0; i < PHASES; i++)
      begin
         n = n + {{PHASE_W{1'b0}}, v[i]};
      end
      return n;
   endfunction

   // Picks the register field or the strapped code, used by every channel.
   function automatic bfrs_resp_t bfrs_sel_resp(input logic indiv, input logic [1:0] fld,
                                                input logic [1:0] strap);
      return bfrs_resp_t'(indiv ? fld : strap);
   endfunction

   logic [7:0]       ocp_resp_reg;
   logic [7:0]       ocp_resp_next;
   logic [7:0]       lbus_resp_reg;
   logic [7:0]       lbus_resp_next;
   logic [7:0]       lbus_stat_reg;
   logic [7:0]       lbus_stat_next;
   logic [7:0]       ph_stat_reg;
   logic [7:0]       ph_stat_next;
   logic [7:0]       rdata_reg;
   logic [7:0]       rdata_next;
   logic [1:0]       mode_reg;
   logic [1:0]       mode_next;
   logic             mode_cap_reg;
   logic             mode_cap_next;
   logic [1:0]       en_prev_reg;
   logic [1:0]       en_prev_next;
   logic             stop_reg;
   logic             stop_next;
   logic             flag_oe_reg;
   logic             flag_oe_next;
   logic [NCH-1:0]   cond_vec;
   logic [NCH-1:0]   stop_vec;
   bfrs_resp_t       resp_vec [NCH];
   logic             rearm;
   logic [PHASE_W:0] masked_cnt;

   // Fault conditions and the response each one follows.
   always_comb
   begin
      masked_cnt       = bfrs_popcount(phase_disable_mask);
      cond_vec[CH_OV]  = bus_ov_cond;
      cond_vec[CH_UV]  = bus_uv_cond;
      cond_vec[CH_PH]  = ocp_resp_reg[F_PH_EN]
                         && ({masked_cnt, 1'b0} > {2'b00, phase_count});
      resp_vec[CH_OV]  = bfrs_sel_resp(indiv_resp_en, lbus_resp_reg[F_OV_RESP +: 2], mode_reg);
      resp_vec[CH_UV]  = bfrs_sel_resp(indiv_resp_en, lbus_resp_reg[F_UV_RESP +: 2], mode_reg);
      resp_vec[CH_PH]  = bfrs_sel_resp(indiv_resp_en, ocp_resp_reg[F_OCP_RESP +: 2], mode_reg);
      rearm            = |({switch_en, chip_en} & ~en_prev_reg);
   end

   bfrs_ch_if ch_if [NCH] ();

   for (genvar g = 0; g < NCH; g++)
   begin : g_ch
      assign ch_if[g].cond  = cond_vec[g];
      assign ch_if[g].resp  = resp_vec[g];
      assign ch_if[g].rearm = rearm;
      assign stop_vec[g]    = ch_if[g].stop;
      bfrs_fault_chan #(
         .DELAY_CYC (HICCUP_CYCLES)
      ) u_chan (
         .clock (clock),
         .nrst  (nrst),
         .ch    (ch_if[g].chan)
      );
   end

   // Register writes, sticky status and pin state. A fault present in the
   // same cycle as a write-one clear keeps its status bit set.
   always_comb
   begin
      ocp_resp_next  = ocp_resp_reg;
      lbus_resp_next = lbus_resp_reg;
      lbus_stat_next = lbus_stat_reg;
      ph_stat_next   = ph_stat_reg;
      if (reg_wr_en && reg_addr == OFF_OCP_RESP)
      begin
         ocp_resp_next = reg_wdata;
      end
      if (reg_wr_en && reg_addr == OFF_LBUS_RESP)
      begin
         lbus_resp_next = reg_wdata;
      end
      if (reg_wr_en && reg_addr == OFF_LBUS_STAT)
      begin
         lbus_stat_next = lbus_stat_next & ~reg_wdata;
      end
      if (reg_wr_en && reg_addr == OFF_PHASE_STAT)
      begin
         ph_stat_next = ph_stat_next & ~reg_wdata;
      end
      if (cond_vec[CH_OV])
      begin
         lbus_stat_next[ST_OV] = 1'b1;
      end
      if (cond_vec[CH_UV])
      begin
         lbus_stat_next[ST_UV] = 1'b1;
      end
      if (cond_vec[CH_PH])
      begin
         ph_stat_next[ST_PH] = 1'b1;
      end
      case (reg_addr)
         OFF_OCP_RESP:   rdata_next = ocp_resp_reg;
         OFF_LBUS_RESP:  rdata_next = lbus_resp_reg;
         OFF_LBUS_STAT:  rdata_next = lbus_stat_reg;
         OFF_PHASE_STAT: rdata_next = ph_stat_reg;
         default:        rdata_next = RDATA_UNMAPPED;
      endcase
      if (!reg_rd_en)
      begin
         rdata_next = rdata_reg;
      end
      // The strap is sampled once, on the first edge after reset release.
      mode_cap_next = 1'b1;
      mode_next     = mode_cap_reg ? mode_reg : mode_resp;
      en_prev_next  = {switch_en, chip_en};
      stop_next     = |stop_vec;
      flag_oe_next  = (lbus_stat_next != REG_RESET) || (ph_stat_next != REG_RESET);
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         ocp_resp_reg  <= REG_RESET;
         lbus_resp_reg <= REG_RESET;
         lbus_stat_reg <= REG_RESET;
         ph_stat_reg   <= REG_RESET;
         rdata_reg     <= REG_RESET;
         mode_reg      <= R_FLAG;
         mode_cap_reg  <= 1'b0;
         en_prev_reg   <= 2'b11;
         stop_reg      <= 1'b0;
         flag_oe_reg   <= 1'b0;
      end
      else
      begin
         ocp_resp_reg  <= ocp_resp_next;
         lbus_resp_reg <= lbus_resp_next;
         lbus_stat_reg <= lbus_stat_next;
         ph_stat_reg   <= ph_stat_next;
         rdata_reg     <= rdata_next;
         mode_reg      <= mode_next;
         mode_cap_reg  <= mode_cap_next;
         en_prev_reg   <= en_prev_next;
         stop_reg      <= stop_next;
         flag_oe_reg   <= flag_oe_next;
      end
   end

   // The flag pin is open drain: it only ever pulls low.
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         fault_flag_out_n_o <= 1'b0;
      end
      else
      begin
         fault_flag_out_n_o <= 1'b0;
      end
   end

   assign reg_rdata           = rdata_reg;
   assign switch_stop         = stop_reg;
   assign fault_flag_out_n_oe = flag_oe_reg;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   property p_phase_off;
      !ocp_resp_reg[F_PH_EN] |-> !cond_vec[CH_PH] ##1 !ph_stat_reg[ST_PH] || $past(ph_stat_reg[ST_PH]);
   endproperty
   a_phase_off: assert property (p_phase_off) else $error("phase fault raised while disabled");

   property p_phase_stop;
      cond_vec[CH_PH] && (resp_vec[CH_PH] == R_HICCUP || resp_vec[CH_PH] == R_LATCH) |-> ##2 switch_stop;
   endproperty
   a_phase_stop: assert property (p_phase_stop) else $error("phase fault did not stop switching");

   property p_indiv_sel;
      indiv_resp_en |-> resp_vec[CH_UV] == bfrs_resp_t'(lbus_resp_reg[F_UV_RESP +: 2]);
   endproperty
   a_indiv_sel: assert property (p_indiv_sel) else $error("register field not used");

   property p_mode_sel;
      !indiv_resp_en |-> resp_vec[CH_OV] == bfrs_resp_t'(mode_reg) && resp_vec[CH_PH] == bfrs_resp_t'(mode_reg);
   endproperty
   a_mode_sel: assert property (p_mode_sel) else $error("strapped response not used");

   property p_ov_flag;
      bus_ov_cond |=> lbus_stat_reg[ST_OV] ##1 fault_flag_out_n_oe;
   endproperty
   a_ov_flag: assert property (p_ov_flag) else $error("overvoltage not flagged");

   property p_uv_flag;
      bus_uv_cond |=> lbus_stat_reg[ST_UV] && fault_flag_out_n_oe;
   endproperty
   a_uv_flag: assert property (p_uv_flag) else $error("undervoltage not flagged");

   property p_reg_rw;
      reg_wr_en && reg_addr == OFF_LBUS_RESP ##1 reg_rd_en && !reg_wr_en && reg_addr == OFF_LBUS_RESP
      |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_reg_rw: assert property (p_reg_rw) else $error("response register readback wrong");

   property p_flag_hold;
      (lbus_stat_reg != REG_RESET) |-> fault_flag_out_n_oe && !fault_flag_out_n_o;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag released while status set");

   c_ov_latch: cover property (bus_ov_cond && resp_vec[CH_OV] == R_LATCH ##2 switch_stop);
   c_phase_fault: cover property (cond_vec[CH_PH] ##2 switch_stop);
   c_flag_release: cover property ($fell(fault_flag_out_n_oe));
endmodule

// *** shared/bfrs_pkg.sv ***
// Shared constants and types for the bus fault response select block.
package bfrs_pkg;
   // Register command codes.
   localparam logic [7:0] OFF_OCP_RESP   = 8'hB6;
   localparam logic [7:0] OFF_LBUS_RESP  = 8'hB7;
   localparam logic [7:0] OFF_LBUS_STAT  = 8'hD7;
   localparam logic [7:0] OFF_PHASE_STAT = 8'hE0;
   localparam logic [7:0] REG_RESET      = 8'h00;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
   // Field positions.
   localparam int F_PH_EN    = 5;
   localparam int F_OCP_RESP = 6;
   localparam int F_OV_RESP  = 0;
   localparam int F_UV_RESP  = 2;
   localparam int ST_OV      = 0;
   localparam int ST_UV      = 1;
   localparam int ST_PH      = 0;
   // Fault channels.
   localparam int NCH   = 3;
   localparam int CH_OV = 0;
   localparam int CH_UV = 1;
   localparam int CH_PH = 2;
   // Phase configuration.
   localparam int MAX_PHASES = 4;
   localparam int PHASE_W    = 3;
   // Hiccup restart delay.
   localparam int unsigned HICCUP_MS  = 500;
   localparam int unsigned CLK_HZ     = 100_000_000;
   localparam int unsigned HICCUP_CYC = HICCUP_MS * (CLK_HZ / 1000);
   typedef enum logic [1:0] {
      R_FLAG   = 2'h0,
      R_HICCUP = 2'h1,
      R_LATCH  = 2'h2,
      R_FLAG2  = 2'h3
   } bfrs_resp_t;
   typedef enum logic [3:0] {
      CH_RUN   = 4'h1,
      CH_WAIT  = 4'h2,
      CH_COUNT = 4'h4,
      CH_HOLD  = 4'h8
   } bfrs_ch_st_t;
endpackage

// *** shared/bfrs_ch_if.sv ***
// Control link between the register bank and one fault response channel.
`timescale 1ns/1ps
interface bfrs_ch_if;
   import bfrs_pkg::*;
   logic       cond;
   bfrs_resp_t resp;
   logic       rearm;
   logic       stop;
   modport chan (input cond, input resp, input rearm, output stop);
   modport ctrl (output cond, output resp, output rearm, input stop);
endinterface

// *** verilog/bfrs_fault_chan.sv ***
// One fault channel: flag only, hiccup with delayed restart, or latch-off.
`timescale 1ns/1ps
module bfrs_fault_chan
   import bfrs_pkg::*;
#(
   parameter int unsigned DELAY_CYC = HICCUP_CYC
)
(
   input wire logic clock,
   input wire logic nrst,
   bfrs_ch_if.chan  ch
);
   localparam int CW = $clog2(DELAY_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(DELAY_CYC - 1);
   localparam logic [CW-1:0] ZERO = '0;
   localparam logic [CW-1:0] ONE  = CW'(1);

   if (DELAY_CYC < 1)
   begin : g_chk
      $error("DELAY_CYC must be at least one cycle");
   end

   bfrs_ch_st_t     st_reg;
   bfrs_ch_st_t     st_next;
   logic [CW-1:0]   cnt_reg;
   logic [CW-1:0]   cnt_next;

   // The delay only starts once the condition has gone away, so a fault that
   // persists keeps switching stopped indefinitely.
   always_comb
   begin
      st_next  = st_reg;
      cnt_next = cnt_reg;
      case (st_reg)
         // Flag-only codes 00 and 11 never leave this state, so switching keeps running.
         CH_RUN:
         begin
            if (ch.cond && ch.resp == R_HICCUP)
            begin
               st_next = CH_WAIT;
            end
            else if (ch.cond && ch.resp == R_LATCH)
            begin
               st_next = CH_HOLD;
            end
         end
         CH_WAIT:
         begin
            if (!ch.cond)
            begin
               st_next  = CH_COUNT;
               cnt_next = ZERO;
            end
         end
         CH_COUNT:
         begin
            if (ch.cond)
            begin
               st_next = CH_WAIT;
            end
            else if (cnt_reg == LAST)
            begin
               st_next = CH_RUN;
            end
            else
            begin
               cnt_next = cnt_reg + ONE;
            end
         end
         CH_HOLD:
         begin
            if (ch.rearm)
            begin
               st_next = CH_RUN;
            end
         end
         default:
         begin
            st_next = CH_RUN;
         end
      endcase
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         st_reg  <= CH_RUN;
         cnt_reg <= ZERO;
      end
      else
      begin
         st_reg  <= st_next;
         cnt_reg <= cnt_next;
      end
   end

   assign ch.stop = (st_reg != CH_RUN);

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   property p_trip_hiccup;
      st_reg == CH_RUN && ch.cond && ch.resp == R_HICCUP |=> st_reg == CH_WAIT && ch.stop;
   endproperty
   a_trip_hiccup: assert property (p_trip_hiccup) else $error("hiccup did not stop switching");

   property p_trip_latch;
      st_reg == CH_RUN && ch.cond && ch.resp == R_LATCH |=> st_reg == CH_HOLD;
   endproperty
   a_trip_latch: assert property (p_trip_latch) else $error("latch-off not entered");

   property p_flag_only;
      st_reg == CH_RUN && (ch.resp == R_FLAG || ch.resp == R_FLAG2) |=> !ch.stop;
   endproperty
   a_flag_only: assert property (p_flag_only) else $error("flag-only code stopped switching");

   property p_restart;
      st_reg == CH_COUNT && !ch.cond && cnt_reg == LAST |=> !ch.stop;
   endproperty
   a_restart: assert property (p_restart) else $error("no restart after hiccup delay");

   property p_latch_hold;
      st_reg == CH_HOLD && !ch.rearm |=> ch.stop;
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch-off released without toggle");

   property p_count_stopped;
      st_reg == CH_COUNT |-> ch.stop && cnt_reg <= LAST;
   endproperty
   a_count_stopped: assert property (p_count_stopped) else $error("counting while switching");

   c_hiccup_done: cover property (st_reg == CH_COUNT ##1 st_reg == CH_RUN);
   c_latch_release: cover property (st_reg == CH_HOLD ##1 st_reg == CH_RUN);
endmodule

// *** verif/bfrs_host.sv ***
// Register bus master standing in for the system controller.
`timescale 1ns/1ps
module bfrs_host
(
   input  wire logic       clock,
   input  wire logic [7:0] reg_rdata,
   output logic            reg_wr_en,
   output logic            reg_rd_en,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata
);
   initial
   begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
   end

   // Strobes last exactly one cycle, so a write is never taken twice.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr_en <= 1'b1;
      @(posedge clock);
      reg_wr_en <= 1'b0;
   endtask

   // A write followed at once by a read of the same code, with no idle cycle between.
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] dw, output logic [7:0] dr);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= dw;
      reg_wr_en <= 1'b1;
      @(posedge clock);
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b1;
      @(posedge clock);
      reg_rd_en <= 1'b0;
      @(posedge clock);
      dr = reg_rdata;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_rd_en <= 1'b1;
      @(posedge clock);
      reg_rd_en <= 1'b0;
      @(posedge clock);
      d = reg_rdata;
   endtask
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for the bus fault response select block.
`timescale 1ns/1ps
module tb_top;
   import bfrs_pkg::*;
   localparam int HC = 8;
   logic        clock = 1'b0;
   logic        nrst = 1'b0;
   logic        indiv_resp_en = 1'b1;
   logic [1:0]  mode_resp = 2'h0;
   logic [3:0]  phase_disable_mask = 4'h0;
   logic [2:0]  phase_count = 3'h4;
   logic        bus_ov_cond = 1'b0;
   logic        bus_uv_cond = 1'b0;
   logic        switch_en = 1'b1;
   logic        chip_en = 1'b1;
   logic        reg_wr_en;
   logic        reg_rd_en;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic        switch_stop;
   logic        flag_o;
   logic        flag_oe;
   int          miscompares = 0;
   int          tests_run = 0;
   logic [31:0] seed = 32'h17015577;
   logic [7:0]  model [int];
   logic [7:0]  d;

   always #5 clock = ~clock;

   bfrs_host i_bfrs_host (.clock(clock), .reg_rdata(reg_rdata), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

   bfrs_top #(.HICCUP_CYCLES(HC), .PHASES(4)) i_bfrs_top (.clock(clock), .nrst(nrst),
      .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .indiv_resp_en(indiv_resp_en), .mode_resp(mode_resp),
      .phase_disable_mask(phase_disable_mask), .phase_count(phase_count), .bus_ov_cond(bus_ov_cond),
      .bus_uv_cond(bus_uv_cond), .switch_en(switch_en), .chip_en(chip_en),
      .switch_stop(switch_stop), .fault_flag_out_n_o(flag_o), .fault_flag_out_n_oe(flag_oe));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      tests_run++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic do_reset(input logic [1:0] m, input logic ind);
      @(posedge clock);
      nrst <= 1'b0;
      mode_resp <= m;
      indiv_resp_en <= ind;
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      model.delete();
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      i_bfrs_host.wr(a, v);
      if (a == OFF_OCP_RESP || a == OFF_LBUS_RESP)
         model[a] = v;
   endtask

   task automatic rd_model(input logic [7:0] a);
      i_bfrs_host.rd(a, d);
      check("register", model.exists(a) ? model[a] : REG_RESET, d);
   endtask

   // Raises one fault, checks the response, then removes it and clears the status.
   task automatic run_case(input int ch, input logic [1:0] code, input logic [1:0] eff);
      logic [7:0] sa;
      logic [7:0] sb;
      logic       hold;
      int         n;
      sa = (ch == CH_PH) ? OFF_PHASE_STAT : OFF_LBUS_STAT;
      sb = (ch == CH_PH) ? 8'h01 : 8'(1 << ch);
      hold = (eff == R_HICCUP) || (eff == R_LATCH);
      if (ch == CH_PH)
         wr_reg(OFF_OCP_RESP, {code, 6'h20});
      else
         wr_reg(OFF_LBUS_RESP, 8'(code) << (2 * ch));
      @(posedge clock);
      if (ch == CH_OV)
         bus_ov_cond <= 1'b1;
      else if (ch == CH_UV)
         bus_uv_cond <= 1'b1;
      else
         phase_disable_mask <= 4'h7;
      repeat (4) @(posedge clock);
      #1;
      check("switch_stop", 8'(hold), 8'(switch_stop));
      check("flag_oe", 8'h01, 8'(flag_oe));
      check("flag_o", 8'h00, 8'(flag_o));
      i_bfrs_host.rd(sa, d);
      check("status", sb, d);
      @(posedge clock);
      bus_ov_cond <= 1'b0;
      bus_uv_cond <= 1'b0;
      phase_disable_mask <= 4'h0;
      #1;
      n = 0;
      while (switch_stop === 1'b1 && n < 40)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      check("restart", eff == R_HICCUP ? 8'(HC + 2) : (eff == R_LATCH ? 8'd40 : 8'd0), 8'(n));
      if (eff == R_LATCH)
      begin
         @(posedge clock);
         if (ch == CH_UV)
            chip_en <= 1'b0;
         else
            switch_en <= 1'b0;
         repeat (2) @(posedge clock);
         chip_en <= 1'b1;
         switch_en <= 1'b1;
         repeat (4) @(posedge clock);
         #1;
         check("latch_release", 8'h00, 8'(switch_stop));
      end
      i_bfrs_host.wr(sa, sb);
      i_bfrs_host.rd(sa, d);
      check("status_clear", 8'h00, d);
      #1;
      check("flag_oe_clear", 8'h00, 8'(flag_oe));
      $display("case channel %0d code %0d done", ch, code);
   endtask

   initial
   begin
      #600_000;
      miscompares++;
      finish_test();
   end

   initial
   begin
      do_reset(2'h0, 1'b1);
      rd_model(OFF_OCP_RESP);
      rd_model(OFF_LBUS_RESP);
      rd_model(OFF_LBUS_STAT);
      rd_model(OFF_PHASE_STAT);
      repeat (4)
      begin
         seed = lfsr(seed);
         wr_reg(OFF_LBUS_RESP, seed[7:0]);
         wr_reg(OFF_OCP_RESP, seed[15:8]);
         wr_reg(8'h55, seed[23:16]);
         rd_model(OFF_LBUS_RESP);
         rd_model(OFF_OCP_RESP);
         rd_model(8'h55);
         seed = lfsr(seed);
         i_bfrs_host.wr_rd(OFF_LBUS_RESP, seed[7:0], d);
         model[OFF_LBUS_RESP] = seed[7:0];
         check("register_b2b", model[OFF_LBUS_RESP], d);
      end
      $display("test registers done");
      for (int ch = 0; ch < NCH; ch++)
         for (int c = 0; c < 4; c++)
            run_case(ch, 2'(c), 2'(c));
      // Phase masking must stay silent while disabled or at exactly half.
      wr_reg(OFF_OCP_RESP, 8'hC0);
      @(posedge clock);
      phase_disable_mask <= 4'hF;
      repeat (4) @(posedge clock);
      i_bfrs_host.rd(OFF_PHASE_STAT, d);
      check("phase_off", 8'h00, d);
      // The mask drops to half before the enable is set, so no transient trip occurs.
      @(posedge clock);
      phase_disable_mask <= 4'h3;
      wr_reg(OFF_OCP_RESP, 8'hA0);
      repeat (4) @(posedge clock);
      i_bfrs_host.rd(OFF_PHASE_STAT, d);
      check("phase_half", 8'h00, d);
      check("phase_stop", 8'h00, 8'(switch_stop));
      check("phase_oe", 8'h00, 8'(flag_oe));
      @(posedge clock);
      phase_disable_mask <= 4'h0;
      $display("test phase silence done");
      do_reset(2'h1, 1'b0);
      run_case(CH_OV, R_LATCH, R_HICCUP);
      run_case(CH_UV, R_FLAG, R_HICCUP);
      phase_count <= 3'h5;
      run_case(CH_PH, R_FLAG, R_HICCUP);
      $display("test strap done");
      finish_test();
   end
endmodule
